/* include/arr_defs.svh */
`ifndef ARR_DEFS_SVH
`define ARR_DEFS_SVH

// result register offsets, high byte here, low byte at offset plus one
`define ARR_OFS_IBUS 8'h31
`define ARR_OFS_IBAT 8'h33
`define ARR_OFS_BUSV 8'h35
`define ARR_OFS_VAC1 8'h37
`define ARR_OFS_VAC2 8'h39
`define ARR_OFS_VBAT 8'h3B
`define ARR_OFS_VSYS 8'h3D
`define ARR_OFS_TS 8'h3F
`define ARR_OFS_TDIE 8'h41

// control registers
`define ARR_OFS_CHG_CTRL 8'h14
`define ARR_OFS_ADC_CTRL 8'h2E
`define ARR_OFS_ADC_DIS0 8'h2F
`define ARR_OFS_ADC_DIS1 8'h30

// field positions
`define ARR_DISCH_EN_BIT 5
`define ARR_ADC_EN_BIT 7
`define ARR_ADC_ONESHOT_BIT 6
`define ARR_DIS_IBUS_BIT 7
`define ARR_DIS_IBAT_BIT 6
`define ARR_DIS_BUSV_BIT 5
`define ARR_DIS_VBAT_BIT 4
`define ARR_DIS_VSYS_BIT 3
`define ARR_DIS_TS_BIT 2
`define ARR_DIS_TDIE_BIT 1
`define ARR_DIS_VAC2_BIT 5
`define ARR_DIS_VAC1_BIT 4

// writable masks and reset values
`define ARR_CHG_CTRL_MASK 8'h20
`define ARR_ADC_CTRL_MASK 8'hFC
`define ARR_ADC_DIS0_MASK 8'hFE
`define ARR_ADC_DIS1_MASK 8'hF0
`define ARR_CHG_CTRL_RST 8'h00
`define ARR_ADC_CTRL_RST 8'h30
`define ARR_ADC_DIS_RST 8'h00
`define ARR_RES_RST 16'h0000

// channel count and result limits, two's complement
`define ARR_NUM_CH 9
`define ARR_IBUS_MAX 16'h1388
`define ARR_IBUS_MIN 16'hEC78
`define ARR_IBAT_MAX 16'h1F40
`define ARR_IBAT_MIN 16'hE0C0
`define ARR_VIN_MAX 16'h7530
`define ARR_VBAT_MAX 16'h4E20
`define ARR_VSYS_MAX 16'h5DC0
`define ARR_TS_MAX 16'h03FF
`define ARR_TDIE_MAX 16'h012C
`define ARR_TDIE_MIN 16'hFFB0
`define ARR_ZERO 16'h0000

`endif

/* include/arr_pkg.sv */
package arr_pkg;
	typedef enum logic [3:0] {
		ARR_CH_IBUS = 4'h0,
		ARR_CH_IBAT = 4'h1,
		ARR_CH_BUSV = 4'h2,
		ARR_CH_VAC1 = 4'h3,
		ARR_CH_VAC2 = 4'h4,
		ARR_CH_VBAT = 4'h5,
		ARR_CH_VSYS = 4'h6,
		ARR_CH_TS = 4'h7,
		ARR_CH_TDIE = 4'h8
	} arr_chan_t;

	typedef enum logic [1:0] {
		ARR_ST_IDLE = 2'b00,
		ARR_ST_SCAN = 2'b01,
		ARR_ST_WAIT = 2'b10
	} arr_state_t;

	typedef logic [15:0] arr_word_t;
endpackage

/* include/arr_seq_if.sv */
interface arr_seq_if;
	logic en;
	logic oneshot;
	logic [8:0] dis;
	logic done;
	logic start;
	arr_pkg::arr_chan_t chan;
	logic pass_done;

	modport seq (
		input en,
		input oneshot,
		input dis,
		input done,
		output start,
		output chan,
		output pass_done
	);

	modport top (
		output en,
		output oneshot,
		output dis,
		output done,
		input start,
		input chan,
		input pass_done
	);
endinterface

/* design/arr_seq.sv */
`include "arr_defs.svh"

module arr_seq (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// link to the register bank
	arr_seq_if.seq bus
);
	arr_pkg::arr_state_t state_q;
	arr_pkg::arr_chan_t chan_q;
	logic start_q;
	logic pass_q;
	logic last_ch;
	logic skip_ch;

	assign last_ch = (chan_q == arr_pkg::ARR_CH_TDIE);
	assign skip_ch = bus.dis[chan_q];
	assign bus.start = start_q;
	assign bus.chan = chan_q;
	assign bus.pass_done = pass_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= arr_pkg::ARR_ST_IDLE;
			chan_q <= arr_pkg::ARR_CH_IBUS;
			start_q <= 1'b0;
			pass_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			pass_q <= 1'b0;
			case (state_q)
				arr_pkg::ARR_ST_IDLE: begin
					chan_q <= arr_pkg::ARR_CH_IBUS;
					if (bus.en)
						state_q <= arr_pkg::ARR_ST_SCAN;
				end
				arr_pkg::ARR_ST_SCAN: begin
					if (!bus.en) begin
						state_q <= arr_pkg::ARR_ST_IDLE;
					end else if (skip_ch) begin
						// disabled channel costs one cycle, no conversion
						chan_q <= last_ch ? arr_pkg::ARR_CH_IBUS : arr_pkg::arr_chan_t'(chan_q + 4'h1);
						pass_q <= last_ch;
					end else begin
						start_q <= 1'b1;
						state_q <= arr_pkg::ARR_ST_WAIT;
					end
				end
				arr_pkg::ARR_ST_WAIT: begin
					// front end must answer every start, else the scan stalls here
					if (bus.done) begin
						chan_q <= last_ch ? arr_pkg::ARR_CH_IBUS : arr_pkg::arr_chan_t'(chan_q + 4'h1);
						pass_q <= last_ch;
						state_q <= arr_pkg::ARR_ST_SCAN;
					end
				end
				default: state_q <= arr_pkg::ARR_ST_IDLE;
			endcase
		end
	end

	property p_no_start_disabled;
		@(posedge clk_in) disable iff (rst_in)
		start_q |-> !$past(bus.dis[chan_q]);
	endproperty
	a_no_start_disabled: assert property (p_no_start_disabled) else $error("disabled channel started");

	property p_no_start_when_off;
		@(posedge clk_in) disable iff (rst_in)
		!bus.en [*2] |=> !start_q;
	endproperty
	a_no_start_when_off: assert property (p_no_start_when_off) else $error("conversion started while off");
endmodule

/* design/arr_regs_top.sv */
`include "arr_defs.svh"

//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////

module arr_regs_top (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// register port behind the serial interface
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// converter front end
	output logic conv_start_out,
	output logic [3:0] conv_chan_out,
	input wire logic conv_done_in,
	input wire logic [15:0] conv_data_in
);

	//////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic [7:0] res_ofs(input logic [3:0] idx);
		logic [7:0] o;
		o = 8'h00;
		case (idx)
			4'h0: o = `ARR_OFS_IBUS;
			4'h1: o = `ARR_OFS_IBAT;
			4'h2: o = `ARR_OFS_BUSV;
			4'h3: o = `ARR_OFS_VAC1;
			4'h4: o = `ARR_OFS_VAC2;
			4'h5: o = `ARR_OFS_VBAT;
			4'h6: o = `ARR_OFS_VSYS;
			4'h7: o = `ARR_OFS_TS;
			4'h8: o = `ARR_OFS_TDIE;
			default: o = 8'h00;
		endcase
		return o;
	endfunction

	// {hit, low byte, index}
	function automatic logic [5:0] res_dec(input logic [7:0] a);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < `ARR_NUM_CH; i++) begin
			if (a == res_ofs(4'(i)))
				r = {1'b1, 1'b0, 4'(i)};
			else if (a == res_ofs(4'(i)) + 8'h01)
				r = {1'b1, 1'b1, 4'(i)};
		end
		return r;
	endfunction

	// raw codes outside the range are pinned to its ends
	function automatic arr_pkg::arr_word_t clamp_res(input logic [3:0] ch, input logic [15:0] v,
			input logic neg_ok);
		logic signed [15:0] lo;
		logic signed [15:0] hi;
		logic signed [15:0] sv;
		sv = $signed(v);
		lo = $signed(`ARR_ZERO);
		hi = $signed(`ARR_ZERO);
		case (ch)
			4'h0: begin
				lo = $signed(`ARR_IBUS_MIN);
				hi = $signed(`ARR_IBUS_MAX);
			end
			4'h1: begin
				lo = neg_ok ? $signed(`ARR_IBAT_MIN) : $signed(`ARR_ZERO);
				hi = $signed(`ARR_IBAT_MAX);
			end
			4'h2, 4'h3, 4'h4: hi = $signed(`ARR_VIN_MAX);
			4'h5: hi = $signed(`ARR_VBAT_MAX);
			4'h6: hi = $signed(`ARR_VSYS_MAX);
			4'h7: hi = $signed(`ARR_TS_MAX);
			4'h8: begin
				lo = $signed(`ARR_TDIE_MIN);
				hi = $signed(`ARR_TDIE_MAX);
			end
			default: hi = $signed(`ARR_ZERO);
		endcase
		if (sv < lo)
			sv = lo;
		else if (sv > hi)
			sv = hi;
		return arr_pkg::arr_word_t'(sv);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// state

	arr_seq_if sif();

	logic [7:0] chg_ctrl_q;
	logic [7:0] adc_ctrl_q;
	logic [7:0] adc_dis0_q;
	logic [7:0] adc_dis1_q;
	arr_pkg::arr_word_t res_q [`ARR_NUM_CH];
	logic [7:0] shadow_q;
	logic [7:0] shadow_ofs_q;
	logic shadow_vld_q;
	logic [7:0] rdata_d;

	arr_seq u_seq (
		.clk_in(core_clk_in),
		.rst_in(rst_in),
		.bus(sif.seq)
	);

	//////////////////////////////////////////////////////////////////////////
	// decode

	logic [5:0] rd_dec;
	logic rd_hit;
	logic rd_lsb;
	logic [3:0] rd_idx;
	logic wr_chg;
	logic wr_ctrl;
	logic wr_dis0;
	logic wr_dis1;
	logic disch_en;
	logic store;
	arr_pkg::arr_word_t store_val;
	logic [16*`ARR_NUM_CH-1:0] res_flat;

	assign rd_dec = res_dec(reg_addr_in);
	assign rd_hit = rd_dec[5];
	assign rd_lsb = rd_dec[4];
	assign rd_idx = rd_dec[3:0];
	// result offsets are absent here, so host writes to them fall away
	assign wr_chg = reg_wr_in && (reg_addr_in == `ARR_OFS_CHG_CTRL);
	assign wr_ctrl = reg_wr_in && (reg_addr_in == `ARR_OFS_ADC_CTRL);
	assign wr_dis0 = reg_wr_in && (reg_addr_in == `ARR_OFS_ADC_DIS0);
	assign wr_dis1 = reg_wr_in && (reg_addr_in == `ARR_OFS_ADC_DIS1);
	assign disch_en = chg_ctrl_q[`ARR_DISCH_EN_BIT];

	assign sif.en = adc_ctrl_q[`ARR_ADC_EN_BIT];
	assign sif.oneshot = adc_ctrl_q[`ARR_ADC_ONESHOT_BIT];
	assign sif.done = conv_done_in;
	assign sif.dis = {
		adc_dis0_q[`ARR_DIS_TDIE_BIT],
		adc_dis0_q[`ARR_DIS_TS_BIT],
		adc_dis0_q[`ARR_DIS_VSYS_BIT],
		adc_dis0_q[`ARR_DIS_VBAT_BIT],
		adc_dis1_q[`ARR_DIS_VAC2_BIT],
		adc_dis1_q[`ARR_DIS_VAC1_BIT],
		adc_dis0_q[`ARR_DIS_BUSV_BIT],
		adc_dis0_q[`ARR_DIS_IBAT_BIT],
		adc_dis0_q[`ARR_DIS_IBUS_BIT]
	};

	// a late answer after disable or enable drop is thrown away
	assign store = conv_done_in && sif.en && !sif.dis[sif.chan];
	assign store_val = clamp_res(sif.chan, conv_data_in, disch_en);

	assign conv_start_out = sif.start;
	assign conv_chan_out = sif.chan;

	//////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			chg_ctrl_q <= `ARR_CHG_CTRL_RST;
			adc_dis0_q <= `ARR_ADC_DIS_RST;
			adc_dis1_q <= `ARR_ADC_DIS_RST;
		end else begin
			if (wr_chg)
				chg_ctrl_q <= reg_wdata_in & `ARR_CHG_CTRL_MASK;
			if (wr_dis0)
				adc_dis0_q <= reg_wdata_in & `ARR_ADC_DIS0_MASK;
			if (wr_dis1)
				adc_dis1_q <= reg_wdata_in & `ARR_ADC_DIS1_MASK;
		end
	end

	// one-shot drops the enable after a full pass; a host write that cycle wins
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			adc_ctrl_q <= `ARR_ADC_CTRL_RST;
		else if (wr_ctrl)
			adc_ctrl_q <= reg_wdata_in & `ARR_ADC_CTRL_MASK;
		else if (sif.pass_done && sif.oneshot)
			adc_ctrl_q[`ARR_ADC_EN_BIT] <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////////
	// result registers

	for (genvar i = 0; i < `ARR_NUM_CH; i++) begin : g_res
		always_ff @(posedge core_clk_in) begin
			if (rst_in)
				res_q[i] <= `ARR_RES_RST;
			else if (store && (sif.chan == 4'(i)))
				res_q[i] <= store_val;
		end
		assign res_flat[16*i +: 16] = res_q[i];
	end

	//////////////////////////////////////////////////////////////////////////
	// read path

	// high byte read freezes the low byte so a pair never tears
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr_in)
			`ARR_OFS_CHG_CTRL: rdata_d = chg_ctrl_q;
			`ARR_OFS_ADC_CTRL: rdata_d = adc_ctrl_q;
			`ARR_OFS_ADC_DIS0: rdata_d = adc_dis0_q;
			`ARR_OFS_ADC_DIS1: rdata_d = adc_dis1_q;
			default: begin
				if (rd_hit && !rd_lsb)
					rdata_d = res_q[rd_idx][15:8];
				else if (rd_hit && shadow_vld_q && (shadow_ofs_q == reg_addr_in))
					rdata_d = shadow_q;
				else if (rd_hit)
					rdata_d = res_q[rd_idx][7:0];
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in)
				reg_rdata_out <= rdata_d;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			shadow_q <= 8'h00;
			shadow_ofs_q <= 8'h00;
			shadow_vld_q <= 1'b0;
		end else if (reg_rd_in && rd_hit && !rd_lsb) begin
			shadow_q <= res_q[rd_idx][7:0];
			shadow_ofs_q <= reg_addr_in + 8'h01;
			shadow_vld_q <= 1'b1;
		end else if (reg_rd_in && rd_hit) begin
			shadow_vld_q <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// checks

	property p_ibus_store;
		@(posedge core_clk_in) disable iff (rst_in)
		store && sif.chan == arr_pkg::ARR_CH_IBUS && $signed(conv_data_in) >= 0
			&& $signed(conv_data_in) <= 5000 |=> res_q[0] == $past(conv_data_in);
	endproperty
	a_ibus_store: assert property (p_ibus_store) else $error("bus current not stored as-is");

	property p_ibus_neg;
		@(posedge core_clk_in) disable iff (rst_in)
		store && sif.chan == arr_pkg::ARR_CH_IBUS && conv_data_in[15] |=> res_q[0][15];
	endproperty
	a_ibus_neg: assert property (p_ibus_neg) else $error("reverse bus current lost its sign");

	property p_ibus_range;
		@(posedge core_clk_in) disable iff (rst_in)
		$signed(res_q[0]) <= 5000 && $signed(res_q[0]) >= -5000;
	endproperty
	a_ibus_range: assert property (p_ibus_range) else $error("bus current out of range");

	property p_ibat_charge;
		@(posedge core_clk_in) disable iff (rst_in)
		store && sif.chan == arr_pkg::ARR_CH_IBAT && $signed(conv_data_in) > 0
			&& $signed(conv_data_in) <= 8000 |=> res_q[1] == $past(conv_data_in);
	endproperty
	a_ibat_charge: assert property (p_ibat_charge) else $error("charge current not stored");

	property p_ibat_no_neg;
		@(posedge core_clk_in) disable iff (rst_in)
		store && sif.chan == arr_pkg::ARR_CH_IBAT && !disch_en |=> !res_q[1][15];
	endproperty
	a_ibat_no_neg: assert property (p_ibat_no_neg) else $error("discharge shown while sensing off");

	property p_ibat_range;
		@(posedge core_clk_in) disable iff (rst_in)
		$signed(res_q[1]) <= 8000 && $signed(res_q[1]) >= -8000;
	endproperty
	a_ibat_range: assert property (p_ibat_range) else $error("battery current out of range");

	property p_busv_read;
		@(posedge core_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == `ARR_OFS_BUSV |=> reg_rvalid_out && reg_rdata_out == $past(res_q[2][15:8]);
	endproperty
	a_busv_read: assert property (p_busv_read) else $error("bus voltage high byte misread");

	property p_ts_range;
		@(posedge core_clk_in) disable iff (rst_in)
		$signed(res_q[7]) >= 0 && $signed(res_q[7]) <= 1023;
	endproperty
	a_ts_range: assert property (p_ts_range) else $error("thermistor ratio out of range");

	property p_tdie_range;
		@(posedge core_clk_in) disable iff (rst_in)
		$signed(res_q[8]) >= -80 && $signed(res_q[8]) <= 300;
	endproperty
	a_tdie_range: assert property (p_tdie_range) else $error("die temperature out of range");

	property p_hold_when_off;
		@(posedge core_clk_in) disable iff (rst_in)
		!sif.en |=> $stable(res_flat);
	endproperty
	a_hold_when_off: assert property (p_hold_when_off) else $error("result moved while disabled");

	property p_write_ignored;
		@(posedge core_clk_in) disable iff (rst_in)
		reg_wr_in && !store |=> $stable(res_flat);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write changed a result");

	property p_reset_zero;
		@(posedge core_clk_in) disable iff (rst_in)
		$past(rst_in) |-> res_flat == '0 && adc_ctrl_q == `ARR_ADC_CTRL_RST;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("state not cleared by reset");
endmodule

/* testbench/arr_conv_model.sv */
//////////////////////////////////////////////////////////////////////////////
// converter front end: one word per start, after a bench-set delay
module arr_conv_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// converter link
	input wire logic conv_start_in,
	input wire logic [3:0] conv_chan_in,
	output logic conv_done_out,
	output logic [15:0] conv_data_out,
	// bench control
	input wire logic [15:0] tbl_in [9],
	input wire logic [7:0] delay_in
);
	timeunit 1ns;
	timeprecision 1ps;

	logic busy_q;
	logic [3:0] chan_q;
	logic [7:0] cnt_q;

	//////////////////////////////////////////////////////////////////////////////
	// data toggles outside done, so a stale word never passes for a fresh one
	always @(posedge clk_in) begin
		conv_done_out <= 1'b0;
		conv_data_out <= ~conv_data_out;
		if (rst_in) begin
			busy_q <= 1'b0;
			chan_q <= 4'h0;
			cnt_q <= 8'h00;
			conv_data_out <= 16'h5A5A;
		end else if (conv_start_in) begin
			// converts only what the device starts
			busy_q <= 1'b1;
			chan_q <= conv_chan_in;
			cnt_q <= delay_in;
		end else if (busy_q && cnt_q <= 8'h01) begin
			busy_q <= 1'b0;
			conv_done_out <= 1'b1;
			conv_data_out <= tbl_in[chan_q];
		end else if (busy_q) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

/* testbench/adc_result_registers_bench.sv */
module adc_result_registers_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic rvalid;
	logic start;
	logic [3:0] chan;
	logic done;
	logic [15:0] data;
	logic [15:0] tbl [9];
	logic [15:0] exp_v [9];
	logic [7:0] delay = 8'h01;
	logic [8:0] off = 9'h000;
	logic [15:0] w;
	logic [7:0] b;
	logic [7:0] ctl_a [5] = '{8'h2E, 8'h14, 8'h2F, 8'h30, 8'h50};
	logic [7:0] ctl_v [5] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h00};
	int err_total = 0;
	int checks = 0;
	int passes = 0;
	int seed;

	always #5 clk = ~clk;

	arr_regs_top i_dut (
		.core_clk_in(clk),
		.rst_in(rst),
		.reg_addr_in(addr),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_wdata_in(wdata),
		.reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid),
		.conv_start_out(start),
		.conv_chan_out(chan),
		.conv_done_in(done),
		.conv_data_in(data)
	);

	arr_conv_model i_conv (
		.clk_in(clk),
		.rst_in(rst),
		.conv_start_in(start),
		.conv_chan_in(chan),
		.conv_done_out(done),
		.conv_data_out(data),
		.tbl_in(tbl),
		.delay_in(delay)
	);

	// a full scan ends with the last channel's word
	always @(posedge clk) begin
		if (done === 1'b1 && chan === 4'h8) begin
			passes <= passes + 1;
		end
	end

	// every start names a channel that is switched on
	always @(negedge clk) begin
		if (start === 1'b1) begin
			chk({15'h0000, off[chan]}, 16'h0000, "disabled channel started");
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// reference model
	function automatic logic [15:0] clampv(int c, logic [15:0] raw, bit dis);
		int v;
		int lo;
		int hi;
		v = $signed(raw);
		lo = 0;
		hi = 300;
		case (c)
			0: lo = -5000;
			1: lo = dis ? -8000 : 0;
			2, 3, 4: hi = 30000;
			5: hi = 20000;
			6: hi = 24000;
			7: hi = 1023;
			default: lo = -80;
		endcase
		if (c == 0) begin
			hi = 5000;
		end
		if (c == 1) begin
			hi = 8000;
		end
		if (v < lo) begin
			v = lo;
		end
		if (v > hi) begin
			v = hi;
		end
		return 16'(v);
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t ns: %s read %h, model %h", $time, m, g, e);
		end
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// register port
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(negedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr <= a;
		rd <= 1'b1;
		@(negedge clk);
		rd <= 1'b0;
		chk({15'h0000, rvalid}, 16'h0001, "read valid");
		d = rdata;
	endtask

	// high byte first, so the low byte comes from the same sample
	task automatic rd16(input int c, output logic [15:0] v);
		logic [7:0] a;
		a = 8'h31 + 8'(2 * c);
		rd8(a, v[15:8]);
		rd8(a + 8'h01, v[7:0]);
	endtask

	task automatic cmp_all();
		for (int c = 0; c < 9; c++) begin
			rd16(c, w);
			chk(w, exp_v[c], "result");
		end
	endtask

	// keep bits mark channels whose stored value must not move
	task automatic load(input bit wide, input bit dis, input logic [8:0] keep);
		for (int c = 0; c < 9; c++) begin
			tbl[c] = wide ? 16'($urandom) : 16'(int'($urandom_range(600, 0)) - 80);
			if (!keep[c]) begin
				exp_v[c] = clampv(c, tbl[c], dis);
			end
		end
	endtask

	task automatic run(input logic [7:0] ctrl, input int n);
		int t;
		int p0;
		p0 = passes;
		wr8(8'h2E, ctrl);
		t = 0;
		while (passes - p0 < n && t < 3000) begin
			@(negedge clk);
			t++;
		end
		chk({15'h0000, passes - p0 >= n}, 16'h0001, "scan finished");
	endtask

	task automatic end_of_test();
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// sequence
	initial begin
		seed = $urandom(99);
		for (int c = 0; c < 9; c++) begin
			tbl[c] = 16'h0000;
			exp_v[c] = 16'h0000;
		end
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 18; c++) begin
			wr8(8'h31 + 8'(c), 8'hFF);
		end
		cmp_all();
		for (int i = 0; i < 5; i++) begin
			rd8(ctl_a[i], b);
			chk({8'h00, b}, {8'h00, ctl_v[i]}, "control reset");
		end
		// small codes, discharge sense off: negative battery current reads zero
		load(1'b0, 1'b0, 9'h000);
		run(8'h80, 2);
		wr8(8'h2E, 8'h00);
		repeat (10) @(negedge clk);
		cmp_all();
		// full-scale codes, discharge sense on, slow converter
		wr8(8'h14, 8'h20);
		delay = 8'h0C;
		load(1'b1, 1'b1, 9'h000);
		run(8'h80, 2);
		wr8(8'h2E, 8'h00);
		repeat (20) @(negedge clk);
		cmp_all();
		// converter off: new codes must not land
		load(1'b1, 1'b1, 9'h1FF);
		repeat (100) @(negedge clk);
		cmp_all();
		// single scan with the input current and VAC2 channels skipped
		wr8(8'h2F, 8'h81);
		wr8(8'h30, 8'h2F);
		rd8(8'h2F, b);
		chk({8'h00, b}, 16'h0080, "disable 0 readback");
		rd8(8'h30, b);
		chk({8'h00, b}, 16'h0020, "disable 1 readback");
		off = 9'h011;
		delay = 8'h03;
		load(1'b0, 1'b1, 9'h011);
		run(8'hC0, 1);
		repeat (3) @(negedge clk);
		rd8(8'h2E, b);
		chk({8'h00, b}, 16'h0040, "single scan control");
		cmp_all();
		end_of_test();
	end

	// the sequence needs under a thousand cycles; this only catches a hang
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		$display("unexpected at %0t ns: watchdog expired", $time);
		end_of_test();
	end
endmodule
